// [hdl/ccp_pkg.sv]
package ccp_pkg;
   // ======================================
   // register map, byte addresses
   localparam logic [3:0] CCP_OFS_CONTROL = 4'h0;
   localparam logic [3:0] CCP_OFS_CAPSEL = 4'h4;
   localparam logic [3:0] CCP_OFS_VAL_LO = 4'h8;
   localparam logic [3:0] CCP_OFS_VAL_HI = 4'hc;
   localparam logic [3:0] CCP_OFS_PERIOD = 4'h0;
   // ======================================
   // control fields
   localparam int CCP_EN_BIT = 7;
   localparam int CCP_OUT_BIT = 5;
   localparam int CCP_FMT_BIT = 4;
   localparam logic [7:0] CCP_CTRL_WMASK = 8'h9f;
   localparam logic [7:0] CCP_CTRL_RST = 8'h00;
   localparam logic [7:0] CCP_CAPSEL_RST = 8'h00;
   localparam logic [7:0] CCP_VAL_RST = 8'h00;
   localparam logic [7:0] CCP_LIMIT_RST = 8'hff;
   // ======================================
   // mode codes
   localparam logic [3:0] CCP_M_OFF = 4'h0;
   localparam logic [3:0] CCP_M_TOG_CLR = 4'h1;
   localparam logic [3:0] CCP_M_TOG = 4'h2;
   localparam logic [3:0] CCP_M_CAP_ANY = 4'h3;
   localparam logic [3:0] CCP_M_CAP_FALL = 4'h4;
   localparam logic [3:0] CCP_M_CAP_RISE = 4'h5;
   localparam logic [3:0] CCP_M_CAP_R4 = 4'h6;
   localparam logic [3:0] CCP_M_CAP_R16 = 4'h7;
   localparam logic [3:0] CCP_M_SET = 4'h8;
   localparam logic [3:0] CCP_M_CLR = 4'h9;
   localparam logic [3:0] CCP_M_PULSE = 4'ha;
   localparam logic [3:0] CCP_M_PULSE_CLR = 4'hb;
   localparam logic [3:0] CCP_M_PWM = 4'hf;
   // ======================================
   // axi responses
   localparam logic [1:0] CCP_RESP_OKAY = 2'h0;
   localparam logic [1:0] CCP_RESP_SLVERR = 2'h2;
endpackage : ccp_pkg

// [hdl/ccp_unit.sv]
// Operation
// - sleep freezes period timer and pwm state
// - output pin holds level during sleep
// - period timer resumes from held value
// - pwm timed from system clock only
// - reset clears registers but sets the period limit to ff, pin to input
// - control bit 7 enables unit
// - control bit 5 reads output, read-only
// - bit 4 selects left alignment in pwm
// - mode 1111 is pwm, 1100-1110 reserved
// - 1011/1010 pulse on match, 1011 clears timer
// - 1001 drives low, 1000 drives high
// - 0111 every 16th, 0110 every 4th rise
// - 0101 each rise, 0100 each fall
// - 0011 captures on both edges
// - 0010 toggles, 0001 toggles and clears timer
// - 0000 turns off and resets logic
// - every event sets flag, and adc trigger when adc_trigger_select is high
// - source field picks capture input
// - capture copies timer bytes to value bytes
// - compare needs both bytes equal
// - right alignment: low eight, high 1:0
// - left alignment: high eight, low 7:6
module ccp_unit
   import ccp_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_req,
   input wire logic [15:0] sixteen_bit_timer,
   input wire logic mapped_capture_pin,
   input wire logic comparator_one_output,
   input wire logic comparator_two_output,
   input wire logic pin_change_event,
   input wire logic [3:0] logic_cell_outputs,
   input wire logic adc_trigger_select,
   output logic timer_clear,
   output logic unit_event_flag,
   output logic adc_trigger,
   output logic pin_out,
   output logic pin_oe
);
   // ======================================
   // registers
   logic [7:0] ctrl_r, capsel_r, val_lo_r, val_hi_r, limit_r;
   logic [7:0] period_timer_r;
   logic [1:0] sub_r;
   logic [9:0] width_buf_r;
   logic out_r, pulse_r;
   logic [3:0] edge_cnt_r;
   logic [7:0] src_sync_r;
   logic [2:0] cap_sync_r;
   logic aw_hold_r, w_hold_r;
   logic [3:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;

   // ======================================
   // decode
   wire [3:0] mode = ctrl_r[3:0];
   wire enabled = ctrl_r[CCP_EN_BIT];
   wire run = enabled && !sleep_req && (mode != CCP_M_OFF);
   wire is_cap = (mode >= CCP_M_CAP_ANY) && (mode <= CCP_M_CAP_R16);
   wire is_cmp = (mode == CCP_M_TOG_CLR) || (mode == CCP_M_TOG) ||
                 ((mode >= CCP_M_SET) && (mode <= CCP_M_PULSE_CLR));
   wire is_pwm = (mode == CCP_M_PWM);
   wire [7:0] src_vec = {logic_cell_outputs, pin_change_event, comparator_two_output,
                         comparator_one_output, mapped_capture_pin};
   wire cap_in = src_sync_r[capsel_r[2:0]];
   // stages two and three must agree before the accepted level in bit 2 moves,
   // so a one-cycle glitch on a source never counts as an edge
   wire cap_agree = cap_sync_r[1] == cap_sync_r[0];
   wire cap_rise = cap_agree && cap_sync_r[0] && !cap_sync_r[2];
   wire cap_fall = cap_agree && !cap_sync_r[0] && cap_sync_r[2];
   wire cap_edge = (mode == CCP_M_CAP_ANY) ? (cap_rise || cap_fall) :
                   (mode == CCP_M_CAP_FALL) ? cap_fall : cap_rise;
   wire cnt_ok = (mode == CCP_M_CAP_R16) ? (edge_cnt_r == 4'hf) :
                 (mode == CCP_M_CAP_R4) ? (edge_cnt_r[1:0] == 2'h3) : 1'b1;
   wire cap_evt = run && is_cap && cap_edge && cnt_ok;
   wire match = (val_lo_r == sixteen_bit_timer[7:0]) &&
                (val_hi_r == sixteen_bit_timer[15:8]);
   wire cmp_evt = run && is_cmp && match && !pulse_r;
   wire [9:0] width_now = ctrl_r[CCP_FMT_BIT] ? {val_hi_r, val_lo_r[7:6]}
                                              : {val_hi_r[1:0], val_lo_r};
   wire [9:0] tbase = {period_timer_r, sub_r};
   wire period_end = (period_timer_r == limit_r) && (sub_r == 2'h3);
   wire pwm_run = run && is_pwm;
   wire pwm_evt = pwm_run && period_end;
   wire any_evt = cap_evt || cmp_evt || pwm_evt;
   wire clr_mode = (mode == CCP_M_TOG_CLR) || (mode == CCP_M_PULSE_CLR);

   // ======================================
   // axi4-lite slave
   wire wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
   wire wr_ok = (awaddr_r[1:0] == 2'h0);
   wire rd_go = s_axi_arvalid && s_axi_arready;
   wire rd_ok = (s_axi_araddr[1:0] == 2'h0);
   wire wr_ctrl = wr_go && wr_ok && awaddr_r == CCP_OFS_CONTROL && wstrb_r[0];
   wire wr_cap = wr_go && wr_ok && awaddr_r == CCP_OFS_CAPSEL && wstrb_r[0];
   wire wr_lo = wr_go && wr_ok && awaddr_r == CCP_OFS_VAL_LO && wstrb_r[0];
   wire wr_hi = wr_go && wr_ok && awaddr_r == CCP_OFS_VAL_HI && wstrb_r[0];
   // period limit lives in byte 1 of the control word
   wire wr_lim = wr_go && wr_ok && awaddr_r == CCP_OFS_PERIOD && wstrb_r[1];
   wire [7:0] ctrl_rd = {ctrl_r[7], 1'b0, out_r, ctrl_r[4:0]};
   wire [31:0] rd_word = (s_axi_araddr[3:2] == 2'h0) ? {8'h00, period_timer_r, limit_r, ctrl_rd} :
                         (s_axi_araddr[3:2] == 2'h1) ? {24'h000000, 5'h00, capsel_r[2:0]} :
                         (s_axi_araddr[3:2] == 2'h2) ? {24'h000000, val_lo_r} :
                                                       {24'h000000, val_hi_r};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CCP_RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= CCP_RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_hold_r && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? CCP_RESP_OKAY : CCP_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_ok ? rd_word : 32'h00000000;
            s_axi_rresp <= rd_ok ? CCP_RESP_OKAY : CCP_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ======================================
   // configuration and value registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CCP_CTRL_RST;
         capsel_r <= CCP_CAPSEL_RST;
         val_lo_r <= CCP_VAL_RST;
         val_hi_r <= CCP_VAL_RST;
         limit_r <= CCP_LIMIT_RST;
      end else begin
         if (wr_ctrl) ctrl_r <= wdata_r[7:0] & CCP_CTRL_WMASK;
         if (wr_lim) limit_r <= wdata_r[15:8];
         if (wr_cap) capsel_r <= {5'h00, wdata_r[2:0]};
         // hardware capture wins over a same-cycle software write
         if (cap_evt) begin
            val_lo_r <= sixteen_bit_timer[7:0];
            val_hi_r <= sixteen_bit_timer[15:8];
         end else begin
            if (wr_lo) val_lo_r <= wdata_r[7:0];
            if (wr_hi) val_hi_r <= wdata_r[7:0];
         end
      end
   end

   // ======================================
   // capture input synchroniser and prescaler
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_sync_r <= 8'h00;
         cap_sync_r <= 3'h0;
         edge_cnt_r <= 4'h0;
      end else begin
         src_sync_r <= src_vec;
         cap_sync_r[1:0] <= {cap_sync_r[0], cap_in};
         if (cap_agree) cap_sync_r[2] <= cap_sync_r[1];
         if (!enabled || mode == CCP_M_OFF || !is_cap) edge_cnt_r <= 4'h0;
         else if (run && cap_rise && (mode == CCP_M_CAP_R4 || mode == CCP_M_CAP_R16))
            edge_cnt_r <= edge_cnt_r + 4'h1;
      end
   end

   // ======================================
   // period timer, pwm and compare output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_timer_r <= 8'h00;
         sub_r <= 2'h0;
         width_buf_r <= 10'h000;
         out_r <= 1'b0;
         pulse_r <= 1'b0;
         timer_clear <= 1'b0;
         unit_event_flag <= 1'b0;
         adc_trigger <= 1'b0;
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         timer_clear <= 1'b0;
         unit_event_flag <= any_evt;
         adc_trigger <= any_evt && adc_trigger_select;
         pin_oe <= enabled && (is_pwm || is_cmp);
         if (!enabled || mode == CCP_M_OFF) begin
            period_timer_r <= 8'h00;
            sub_r <= 2'h0;
            out_r <= 1'b0;
            pulse_r <= 1'b0;
         end else if (sleep_req) begin
            // nothing moves; the count is kept for wake-up
            period_timer_r <= period_timer_r;
         end else if (pwm_run) begin
            // one step per system clock, so pwm rate follows aclk
            sub_r <= sub_r + 2'h1;
            if (period_end) begin
               period_timer_r <= 8'h00;
               width_buf_r <= width_now;
               out_r <= (width_now != 10'h000);
            end else begin
               if (sub_r == 2'h3) period_timer_r <= period_timer_r + 8'h01;
               if (tbase + 10'h001 == width_buf_r) out_r <= 1'b0;
            end
         end else if (pulse_r) begin
            pulse_r <= 1'b0;
            out_r <= 1'b0;
         end else if (cmp_evt) begin
            timer_clear <= clr_mode;
            case (mode)
               CCP_M_SET: out_r <= 1'b1;
               CCP_M_CLR: out_r <= 1'b0;
               CCP_M_PULSE, CCP_M_PULSE_CLR: begin
                  out_r <= 1'b1;
                  pulse_r <= 1'b1;
               end
               default: out_r <= !out_r;
            endcase
         end
         // the pin keeps the level it had when sleep began, not the next one
         if (!(sleep_req && enabled && mode != CCP_M_OFF)) pin_out <= out_r;
      end
   end

   // ======================================
   // checks
   property p_oe_reset;
      @(posedge aclk) $fell(aresetn) |=> !pin_oe;
   endproperty
   a_oe_reset: assert property (p_oe_reset) else $error("pin not input after reset");
   property p_sleep_hold;
      @(posedge aclk) disable iff (!aresetn)
         sleep_req && $past(sleep_req) && enabled && $past(enabled) && mode != CCP_M_OFF
         |-> $stable(period_timer_r) && $stable(pin_out);
   endproperty
   a_sleep_hold: assert property (p_sleep_hold) else $error("state moved in sleep");
   property p_capture;
      @(posedge aclk) disable iff (!aresetn)
         cap_evt |=> {val_hi_r, val_lo_r} == $past(sixteen_bit_timer);
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");
   property p_flag;
      @(posedge aclk) disable iff (!aresetn) any_evt |=> unit_event_flag;
   endproperty
   a_flag: assert property (p_flag) else $error("event flag missing");
   property p_pulse;
      @(posedge aclk) disable iff (!aresetn)
         cmp_evt && mode == CCP_M_PULSE_CLR |=> out_r && timer_clear ##1 !out_r;
   endproperty
   a_pulse: assert property (p_pulse) else $error("pulse shape wrong");
   property p_set;
      @(posedge aclk) disable iff (!aresetn) cmp_evt && mode == CCP_M_SET |=> ##1 pin_out;
   endproperty
   a_set: assert property (p_set) else $error("set on match failed");
   property p_reserved;
      @(posedge aclk) disable iff (!aresetn)
         mode inside {4'hc, 4'hd, 4'he} |-> !any_evt;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved mode acted");
   property p_outbit;
      @(posedge aclk) disable iff (!aresetn)
         rd_go && s_axi_araddr == CCP_OFS_CONTROL
         |=> s_axi_rdata[CCP_OUT_BIT] == $past(out_r) && !s_axi_rdata[6];
   endproperty
   a_outbit: assert property (p_outbit) else $error("status bit wrong");
   property p_clr;
      @(posedge aclk) disable iff (!aresetn) cmp_evt && mode == CCP_M_CLR |=> !out_r;
   endproperty
   a_clr: assert property (p_clr) else $error("clear on match failed");
   property p_toggle;
      @(posedge aclk) disable iff (!aresetn)
         cmp_evt && (mode == CCP_M_TOG || mode == CCP_M_TOG_CLR) |=> out_r != $past(out_r);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle on match failed");
   property p_timer_clear;
      @(posedge aclk) disable iff (!aresetn) timer_clear |-> $past(cmp_evt && clr_mode);
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("stray timer clear");
   property p_adc;
      @(posedge aclk) disable iff (!aresetn) adc_trigger |-> unit_event_flag;
   endproperty
   a_adc: assert property (p_adc) else $error("trigger without event");
   // mode off must also drop the time base, so pwm restarts from a clean period
   property p_off;
      @(posedge aclk) disable iff (!aresetn)
         mode == CCP_M_OFF |=> period_timer_r == 8'h00 && !out_r;
   endproperty
   a_off: assert property (p_off) else $error("logic not reset in mode off");
   c_capture: cover property (@(posedge aclk) cap_evt);
   c_pwm: cover property (@(posedge aclk) pwm_evt);
   c_toggle: cover property (@(posedge aclk) cmp_evt && mode == CCP_M_TOG);
   c_pulse: cover property (@(posedge aclk) cmp_evt && mode == CCP_M_PULSE_CLR);
   c_sleep: cover property (@(posedge aclk) sleep_req && enabled && is_pwm);
endmodule : ccp_unit

// [verif/ccp_far_model.sv]
module ccp_far_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic run,
   input wire logic timer_clear,
   output logic [15:0] timer
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // sixteen bit timer; a clear request beats load and count
   always_ff @(posedge aclk) begin
      if (!aresetn) timer <= 16'h0000;
      else if (timer_clear) timer <= 16'h0000;
      else if (load) timer <= load_val;
      else if (run) timer <= timer + 16'h0001;
   end
endmodule : ccp_far_model

// [verif/tb.sv]
module tb;
   import ccp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_req = 1'b0;
   logic adc_trigger_select = 1'b0, load = 1'b0, run = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, ra;
   logic [15:0] load_val = 16'h0, sixteen_bit_timer, ev;
   logic [7:0] src = 8'h00, tg, rn, lim = 8'h0f;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer_clear;
   logic unit_event_flag, adc_trigger, pin_out, pin_oe, pb, rise, mt;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [2:0] sel;
   logic [3:0] m;
   logic [9:0] w;
   int num_errors = 0, compares = 0, cyc = 0, flags = 0, adcs = 0, clrs = 0, highs = 0;
   int f0, a0, c0, h0, nr, nh;
   logic [3:0] cm [8] = '{CCP_M_CAP_ANY, CCP_M_CAP_FALL, CCP_M_CAP_RISE, CCP_M_CAP_R4,
      CCP_M_CAP_R16, CCP_M_CAP_RISE, CCP_M_CAP_RISE, CCP_M_CAP_RISE};
   // {enable, match expected, high byte, mode}
   logic [6:0] ct [9] = '{7'h68, 7'h69, 7'h62, 7'h61, 7'h6a, 7'h6b, 7'h58, 7'h08, 7'h4c};
   logic [3:0] ofs [3] = '{CCP_OFS_CAPSEL, CCP_OFS_VAL_LO, CCP_OFS_VAL_HI};

   ccp_unit i_ccp_unit (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_req, .sixteen_bit_timer,
      .mapped_capture_pin(src[0]), .comparator_one_output(src[1]),
      .comparator_two_output(src[2]), .pin_change_event(src[3]),
      .logic_cell_outputs(src[7:4]), .adc_trigger_select, .timer_clear, .unit_event_flag,
      .adc_trigger, .pin_out, .pin_oe);
   ccp_far_model i_ccp_far_model (.aclk, .aresetn, .load, .load_val, .run, .timer_clear,
      .timer(sixteen_bit_timer));

   initial forever #5 aclk = ~aclk;
   // ==========
   // monitor on the falling edge, so counts never race the driving edge
   always @(negedge aclk) begin
      cyc++;
      flags += unit_event_flag;
      adcs += adc_trigger;
      clrs += timer_clear;
      highs += pin_out;
      if (cyc == 20000) begin
         num_errors++;
         test_done();
      end
   end
   // ==========
   // helpers
   task automatic test_done();
      if (num_errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   function automatic bit hit(input logic [3:0] md, input bit r, input int n);
      case (md)
         CCP_M_CAP_ANY: return 1'b1;
         CCP_M_CAP_FALL: return !r;
         CCP_M_CAP_RISE: return r;
         CCP_M_CAP_R4: return r && (n % 4 == 0);
         default: return r && (n % 16 == 0);
      endcase
   endfunction : hit
   function automatic logic exp_pin(input logic [3:0] md, input logic e, input logic p);
      if (!e) return p;
      case (md)
         CCP_M_SET: return 1'b1;
         CCP_M_TOG, CCP_M_TOG_CLR: return !p;
         default: return 1'b0;
      endcase
   endfunction : exp_pin
   // ==========
   // main sequence
   initial begin
      void'($urandom(29));
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      chk({pin_oe, pin_out}, 2'b00);
      rd(CCP_OFS_CONTROL, rv, rsp);
      chk(rv[15:0], {CCP_LIMIT_RST, CCP_CTRL_RST});
      foreach (ofs[i]) begin
         rd(ofs[i], rv, rsp);
         chk(rv[7:0], 8'h00);
      end
      wr(CCP_OFS_CONTROL, {16'h0000, lim, 8'h6c}, rsp);
      rd(CCP_OFS_CONTROL, rv, rsp);
      chk(rv[15:0], {lim, 8'h0c});
      wr(4'h2, 32'h0000_00ff, rsp);
      chk(rsp, CCP_RESP_SLVERR);
      rd(4'h2, rv, rsp);
      chk(rsp, CCP_RESP_SLVERR);
      // every capture kind, each source once; mode off first clears the prescaler
      foreach (cm[k]) begin
         sel = 3'(k);
         ev = 16'($urandom);
         wr(CCP_OFS_CONTROL, {16'h0000, lim, 8'h00}, rsp);
         wr(CCP_OFS_CAPSEL, {29'h0, sel}, rsp);
         wr(CCP_OFS_VAL_LO, {24'h0, ev[7:0]}, rsp);
         wr(CCP_OFS_VAL_HI, {24'h0, ev[15:8]}, rsp);
         wr(CCP_OFS_CONTROL, {16'h0000, lim, 4'h8, cm[k]}, rsp);
         f0 = flags;
         nr = 0;
         nh = 0;
         for (int i = 0; i < ((cm[k] == CCP_M_CAP_R16) ? 32 : 8); i++) begin
            load_val <= 16'($urandom);
            load <= 1'b1;
            @(posedge aclk);
            load <= 1'b0;
            rise = !src[sel];
            src[sel] <= !src[sel];
            nr += rise;
            repeat (8) @(posedge aclk);
            if (hit(cm[k], rise, nr)) begin
               ev = sixteen_bit_timer;
               nh++;
            end
            rd(CCP_OFS_VAL_LO, rv, rsp);
            chk(rv[7:0], ev[7:0]);
            rd(CCP_OFS_VAL_HI, rv, rsp);
            chk(rv[7:0], ev[15:8]);
         end
         chk(flags - f0, nh);
      end
      // compare actions; the timer ramps from zero through the target once, unless the high byte is set
      foreach (ct[k]) begin
         tg = 8'(20 + $urandom % 100);
         m = ct[k][3:0];
         mt = ct[k][5];
         wr(CCP_OFS_VAL_LO, {24'h0, tg}, rsp);
         wr(CCP_OFS_VAL_HI, {31'h0, ct[k][4]}, rsp);
         load_val <= 16'h0000;
         load <= 1'b1;
         wr(CCP_OFS_CONTROL, {16'h0000, lim, ct[k][6], 3'h0, m}, rsp);
         load <= 1'b0;
         adc_trigger_select <= 1'($urandom);
         repeat (2) @(posedge aclk);
         pb = pin_out;
         f0 = flags;
         a0 = adcs;
         c0 = clrs;
         h0 = highs;
         run <= 1'b1;
         repeat (tg + 12) @(posedge aclk);
         run <= 1'b0;
         repeat (2) @(posedge aclk);
         chk(flags - f0, mt);
         chk(adcs - a0, mt & adc_trigger_select);
         chk(clrs - c0, mt && (m == CCP_M_TOG_CLR || m == CCP_M_PULSE_CLR));
         chk(pin_out, exp_pin(m, mt, pb));
         if (m[3:1] == 3'b101) chk(highs - h0, mt);
      end
      // pwm in both layouts, period of (lim + 1) * 4 clocks
      for (int f = 0; f < 2; f++) begin
         w = 10'(1 + $urandom % 63);
         rn = 8'($urandom);
         wr(CCP_OFS_VAL_LO, {24'h0, f[0] ? {w[1:0], rn[5:0]} : w[7:0]}, rsp);
         wr(CCP_OFS_VAL_HI, {24'h0, f[0] ? w[9:2] : {rn[7:2], w[9:8]}}, rsp);
         wr(CCP_OFS_CONTROL, {16'h0000, lim, 3'h4, f[0], CCP_M_PWM}, rsp);
         repeat (200) @(posedge aclk);
         h0 = highs;
         repeat (128) @(posedge aclk);
         chk(highs - h0, 2 * w);
         chk(pin_oe, 1'b1);
         sleep_req <= 1'b1;
         repeat (3) @(posedge aclk);
         pb = pin_out;
         rd(CCP_OFS_CONTROL, ra, rsp);
         repeat (30) begin
            @(posedge aclk);
            chk(pin_out, pb);
         end
         rd(CCP_OFS_CONTROL, rv, rsp);
         chk(rv[23:16], ra[23:16]);
         sleep_req <= 1'b0;
         rd(CCP_OFS_CONTROL, rv, rsp);
         chk(4'(rv[19:16] - ra[19:16]) <= 4'h2, 1'b1);
      end
      // reset in mid-run while the pin is driven
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      chk({pin_oe, pin_out}, 2'b00);
      aresetn <= 1'b1;
      rd(CCP_OFS_CONTROL, rv, rsp);
      chk(rv[15:0], {CCP_LIMIT_RST, CCP_CTRL_RST});
      test_done();
   end
endmodule : tb
